// ===== rtl/pfs_pin_select.sv
// Pin function select: port A multiplexing, clock source choice and reset pin role.
//
// Operation
// - After reset every pin takes primary function.
// - Alternate only with enable and select set.
// - External clock needs the clock mode bit.
// - Source select bit picks clock or crystal.
// - Low reset pin holds device in reset.
// - Reset released synchronously after fixed count.
// - Pin 7 as GPIO disables pin reset.
// - Each pin has its own direction bit.
// - Pins 0 to 2 carry pulse channels.
// - Shared pin 7 defaults to reset role.
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_pin_select
    import pfs_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [`PFS_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic [`PFS_NPINS-1:0] pa_in_i,
    output logic      [`PFS_NPINS-1:0] pa_out_o,
    output logic      [`PFS_NPINS-1:0] pa_oe_o,
    input  wire logic [`PFS_NPWM-1:0]  pulse_ch_i,
    input  wire logic                  clock_input_pin_i,
    input  wire logic                  crystal_pin_i,
    output logic                       ext_clk_o,
    output logic                       ext_clk_en_o,
    input  wire logic                  wdog_rst_i,
    output logic                       int_rst_o
);

    logic [7:0]            dout_r;
    logic [7:0]            dir_r;
    logic [7:0]            per_r;
    logic [7:0]            sel_r;
    logic [1:0]            osc_r;
    logic                  gpio7_r;
    logic                  swrst_r;
    logic [7:0]            pin_r;
    logic                  ack_r;
    logic [31:0]           dat_r;
    logic [`PFS_CNT_W-1:0] cnt_r;
    logic [`PFS_CNT_W-1:0] quiet_r;
    pfs_rst_state_type     state_r;
    logic                  int_rst_r;
    logic [7:0]            out_nxt;
    logic [7:0]            oe_nxt;
    logic                  clk_nxt;
    logic                  wr_stb;
    logic                  rd_stb;
    logic                  pin_rst;
    logic                  rst_src;
    logic                  cfg_rst;

    // Byte lane 0 merge; only the low byte of each register is implemented.
    function automatic logic [7:0] pfs_merge(input logic [7:0] old,
                                             input logic [3:0] sel,
                                             input logic [31:0] dat);
        pfs_merge = sel[0] ? dat[7:0] : old;
    endfunction

    // Alternate function is routed only when both enable and select agree.
    function automatic logic pfs_alt(input logic en, input logic sel);
        pfs_alt = en & sel;
    endfunction

    assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
    assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r;

    // Pin reset counts only while pin 7 holds its reset role.
    assign pin_rst = ~gpio7_r & ~pa_in_i[`PFS_PIN_RST];
    assign rst_src = rst_i | pin_rst | wdog_rst_i | swrst_r;
    // Configuration returns to primary functions on any chip reset.
    assign cfg_rst = rst_i | int_rst_r;

    // Bus acknowledge: one cycle after the request, dropped the next cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
        end
    end

    // Read data; unmapped offsets read as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_stb) begin
            unique case (wb_adr_i)
                `PFS_OFS_DOUT: dat_r <= {24'h00_0000, dout_r};
                `PFS_OFS_DIR:  dat_r <= {24'h00_0000, dir_r};
                `PFS_OFS_PER:  dat_r <= {24'h00_0000, per_r};
                `PFS_OFS_SEL:  dat_r <= {24'h00_0000, sel_r};
                `PFS_OFS_OSC:  dat_r <= {30'h0000_0000, osc_r};
                `PFS_OFS_PIN:  dat_r <= {24'h00_0000, pin_r};
                `PFS_OFS_MISC: dat_r <= {31'h0000_0000, gpio7_r};
                `PFS_OFS_STAT: dat_r <= {31'h0000_0000, state_r == PFS_HOLD};
                default:       dat_r <= 32'h0000_0000;
            endcase
        end
    end

    // Port data and direction registers, one direction bit per pin.
    always_ff @(posedge clk_i) begin
        if (cfg_rst) begin
            dout_r <= `PFS_RST_BYTE;
            dir_r  <= `PFS_RST_BYTE;
        end else if (wr_stb) begin
            if (wb_adr_i == `PFS_OFS_DOUT) begin
                dout_r <= pfs_merge(dout_r, wb_sel_i, wb_dat_i);
            end
            if (wb_adr_i == `PFS_OFS_DIR) begin
                dir_r <= pfs_merge(dir_r, wb_sel_i, wb_dat_i);
            end
        end
    end

    // Peripheral enable and peripheral select registers, cleared on reset.
    always_ff @(posedge clk_i) begin
        if (cfg_rst) begin
            per_r <= `PFS_RST_BYTE;
            sel_r <= `PFS_RST_BYTE;
        end else if (wr_stb) begin
            if (wb_adr_i == `PFS_OFS_PER) begin
                per_r <= pfs_merge(per_r, wb_sel_i, wb_dat_i);
            end
            if (wb_adr_i == `PFS_OFS_SEL) begin
                sel_r <= pfs_merge(sel_r, wb_sel_i, wb_dat_i);
            end
        end
    end

    // Oscillator control: clock mode bit and source select bit.
    always_ff @(posedge clk_i) begin
        if (cfg_rst) begin
            osc_r <= `PFS_RST_OSC;
        end else if (wr_stb && wb_adr_i == `PFS_OFS_OSC && wb_sel_i[0]) begin
            osc_r <= wb_dat_i[1:0];
        end
    end

    // Pin 7 role; a reset always restores the reset role.
    always_ff @(posedge clk_i) begin
        if (cfg_rst) begin
            gpio7_r <= 1'b0;
        end else if (wr_stb && wb_adr_i == `PFS_OFS_MISC && wb_sel_i[0]) begin
            gpio7_r <= wb_dat_i[`PFS_MISC_GPIO7];
        end
    end

    // Software reset request is a one-cycle pulse, never stored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swrst_r <= 1'b0;
        end else begin
            swrst_r <= wr_stb & (wb_adr_i == `PFS_OFS_MISC) & wb_sel_i[0]
                       & wb_dat_i[`PFS_MISC_SWRST];
        end
    end

    // Pin levels captured for software to read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_r <= `PFS_RST_BYTE;
        end else begin
            pin_r <= pa_in_i;
        end
    end

    // Reset sequencer: holds while any source is active, then counts down.
    // Releasing on the clock edge keeps every downstream flop leaving reset together.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= PFS_HOLD;
            cnt_r   <= `PFS_RST_CYCLES;
        end else if (rst_src) begin
            state_r <= PFS_HOLD;
            cnt_r   <= `PFS_RST_CYCLES;
        end else begin
            unique case (state_r)
                PFS_HOLD: begin
                    if (cnt_r == `PFS_CNT_ONE) begin
                        state_r <= PFS_RUN;
                        cnt_r   <= `PFS_CNT_ZERO;
                    end else begin
                        cnt_r <= cnt_r - `PFS_CNT_ONE;
                    end
                end
                PFS_RUN: begin
                    cnt_r <= `PFS_CNT_ZERO;
                end
            endcase
        end
    end

    // Internal reset output follows the sequencer state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_rst_r <= 1'b1;
        end else begin
            int_rst_r <= rst_src | (state_r == PFS_HOLD);
        end
    end

    // Edges since the last reset source, for the release checks only.
    // It saturates so that a long quiet run never wraps back into the window it measures.
    always_ff @(posedge clk_i) begin
        if (rst_src) begin
            quiet_r <= `PFS_CNT_ZERO;
        end else if (quiet_r != `PFS_QUIET_MAX) begin
            quiet_r <= quiet_r + `PFS_CNT_ONE;
        end
    end

    // Pin multiplexer: pulse channels on pins 0 to 2, port logic elsewhere.
    always_comb begin
        out_nxt = dout_r;
        oe_nxt  = dir_r;
        for (int i = 0; i < `PFS_NPWM; i++) begin
            if (pfs_alt(per_r[i], sel_r[i])) begin
                out_nxt[i] = pulse_ch_i[i];
                oe_nxt[i]  = 1'b1;
            end
        end
        // The reset role is input only, so the pin is never driven.
        if (!gpio7_r) begin
            out_nxt[`PFS_PIN_RST] = 1'b0;
            oe_nxt[`PFS_PIN_RST]  = 1'b0;
        end
    end

    // External clock path, gated by the mode bit.
    always_comb begin
        clk_nxt = 1'b0;
        if (osc_r[`PFS_OSC_MODE_BIT]) begin
            clk_nxt = osc_r[`PFS_OSC_SRC_BIT] ? crystal_pin_i
                                              : clock_input_pin_i;
        end
    end

    // Registered pin and clock outputs.
    always_ff @(posedge clk_i) begin
        if (cfg_rst) begin
            pa_out_o     <= `PFS_RST_BYTE;
            pa_oe_o      <= `PFS_RST_BYTE;
            ext_clk_o    <= 1'b0;
            ext_clk_en_o <= 1'b0;
        end else begin
            pa_out_o     <= out_nxt;
            pa_oe_o      <= oe_nxt;
            ext_clk_o    <= clk_nxt;
            ext_clk_en_o <= osc_r[`PFS_OSC_MODE_BIT];
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;
    assign int_rst_o = int_rst_r;

    // Checks kept beside the logic they guard.
    AST_RST_DEFAULT: assert property (@(posedge clk_i)
        $fell(int_rst_r) |-> (per_r == `PFS_RST_BYTE) && (sel_r == `PFS_RST_BYTE))
        else $error("Enables not cleared when reset ends.");

    AST_ALT_NEEDS_BOTH: assert property (@(posedge clk_i) disable iff (cfg_rst)
        !(per_r[0] & sel_r[0]) && !dir_r[0] |=> !pa_oe_o[0])
        else $error("Pin 0 driven without enable and select.");

    AST_PWM_ROUTE: assert property (@(posedge clk_i) disable iff (cfg_rst)
        per_r[1] & sel_r[1] |=> pa_oe_o[1] && pa_out_o[1] == $past(pulse_ch_i[1]))
        else $error("Pulse channel 1 not routed to pin 1.");

    AST_GPIO_PATH: assert property (@(posedge clk_i) disable iff (cfg_rst)
        !per_r[2] |=> pa_out_o[2] == $past(dout_r[2]) && pa_oe_o[2] == $past(dir_r[2]))
        else $error("Pin 2 not on port logic with enable clear.");

    AST_CLK_MODE: assert property (@(posedge clk_i) disable iff (cfg_rst)
        !osc_r[`PFS_OSC_MODE_BIT] |=> !ext_clk_o && !ext_clk_en_o)
        else $error("External clock passed without mode bit.");

    AST_CLK_SRC: assert property (@(posedge clk_i) disable iff (cfg_rst)
        osc_r == 2'h3 |=> ext_clk_o == $past(crystal_pin_i))
        else $error("Crystal source not selected.");

    AST_PIN_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        pin_rst |=> int_rst_r [*3])
        else $error("Reset pin low did not hold reset.");

    AST_RELEASE_LATE: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet_r < `PFS_QUIET_MAX |-> int_rst_r)
        else $error("Internal reset released too early.");

    AST_RELEASE_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        quiet_r == `PFS_QUIET_MAX |-> !int_rst_r)
        else $error("Internal reset not released after count.");

    AST_SWRST_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
        swrst_r |=> int_rst_r)
        else $error("Software reset did not reset the chip.");

    AST_WDOG_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
        wdog_rst_i |=> int_rst_r)
        else $error("Watchdog reset did not reset the chip.");

    AST_PIN7_RESTORE: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(int_rst_r) |-> !gpio7_r)
        else $error("Pin 7 left in port role after reset.");

    AST_PULSE_CHANNEL_0_ROUTE: assert property (@(posedge clk_i) disable iff (cfg_rst)
        per_r[0] & sel_r[0] |=> pa_oe_o[0] && pa_out_o[0] == $past(pulse_ch_i[0]))
        else $error("Pulse channel 0 not routed to pin 0.");

    AST_PULSE_CHANNEL_2_ROUTE: assert property (@(posedge clk_i) disable iff (cfg_rst)
        per_r[2] & sel_r[2] |=> pa_oe_o[2] && pa_out_o[2] == $past(pulse_ch_i[2]))
        else $error("Pulse channel 2 not routed to pin 2.");

    AST_GPIO0_PATH: assert property (@(posedge clk_i) disable iff (cfg_rst)
        !per_r[0] |=> pa_out_o[0] == $past(dout_r[0]))
        else $error("Pin 0 not on port logic with enable clear.");

    AST_GPIO7_NO_RST: assert property (@(posedge clk_i) disable iff (rst_i)
        gpio7_r && !wdog_rst_i && !swrst_r |=> state_r == $past(state_r) ||
                                               state_r == PFS_RUN)
        else $error("Pin 7 in port role caused a reset.");

    AST_PIN7_ROLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !gpio7_r && !cfg_rst |=> !pa_oe_o[`PFS_PIN_RST])
        else $error("Reset pin driven in reset role.");

    AST_DIR_OWN: assert property (@(posedge clk_i) disable iff (cfg_rst)
        !per_r[4] |=> pa_oe_o[4] == $past(dir_r[4]))
        else $error("Pin 4 direction not from its own bit.");

endmodule

// ===== rtl/pfs_defines.svh
// Register offsets, field positions, reset values and counts for pin function select.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_ADR_W        8
`define PFS_OFS_DOUT     8'h00
`define PFS_OFS_DIR      8'h04
`define PFS_OFS_PER      8'h08
`define PFS_OFS_SEL      8'h0c
`define PFS_OFS_OSC      8'h10
`define PFS_OFS_PIN      8'h14
`define PFS_OFS_MISC     8'h18
`define PFS_OFS_STAT     8'h1c
`define PFS_NPINS        8
`define PFS_NPWM         3
`define PFS_PIN_RST      7
`define PFS_OSC_MODE_BIT 0
`define PFS_OSC_SRC_BIT  1
`define PFS_MISC_GPIO7   0
`define PFS_MISC_SWRST   1
`define PFS_RST_BYTE     8'h00
`define PFS_RST_OSC      2'h0
`define PFS_RST_CYCLES   6'h20
`define PFS_CNT_W        6
`define PFS_CNT_ONE      6'h01
`define PFS_CNT_ZERO     6'h00
// Reload count plus one: edges from a source falling to the internal reset releasing.
`define PFS_QUIET_MAX    6'h21
`endif

// ===== rtl/pfs_pkg.sv
// Types shared by the pin function select block.
package pfs_pkg;
    // Internal reset sequencer states.
    typedef enum logic [0:0] {
        PFS_RUN  = 1'b0,
        PFS_HOLD = 1'b1
    } pfs_rst_state_type;
endpackage

// ===== tb/pin_function_select_test.sv
// Self-checking bench for the pin function select block, driven over Wishbone.
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pin_function_select_test;
    import pfs_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  pa_in_i;
    logic [7:0]  pa_out_o;
    logic [7:0]  pa_oe_o;
    logic [2:0]  pulse_ch_i;
    logic        clock_input_pin_i;
    logic        crystal_pin_i;
    logic        ext_clk_o;
    logic        ext_clk_en_o;
    logic        wdog_rst_i;
    logic        int_rst_o;
    logic [31:0] rd;
    int          num_errors;
    int          checked;
    int          cycles;
    int          n;

    pfs_pin_select DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pa_in_i(pa_in_i),
        .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o), .pulse_ch_i(pulse_ch_i),
        .clock_input_pin_i(clock_input_pin_i), .crystal_pin_i(crystal_pin_i),
        .ext_clk_o(ext_clk_o), .ext_clk_en_o(ext_clk_en_o), .wdog_rst_i(wdog_rst_i),
        .int_rst_o(int_rst_o));

    // A 20 ns clock, free running.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // The ceiling sits far above the few hundred cycles the tests need.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    // Prints the verdict once and ends the run.
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Compares one value; unknown bits never match.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high at an edge.
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Lets outputs settle after a number of edges.
    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // Counts edges until the internal reset is released.
    task automatic rel();
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (int_rst_o !== 1'b0 && n < 200);
    endtask

    initial begin
        num_errors = 0;
        checked = 0;
        cycles = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        pa_in_i = 8'h80;
        pulse_ch_i = 3'h0;
        clock_input_pin_i = 1'b0;
        crystal_pin_i = 1'b0;
        wdog_rst_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("oe", 32'h0, pa_oe_o);
        chk("rst", 32'h1, int_rst_o);
        rel();
        chk("count", 33, n);
        wb_io(1'b0, 8'h18, 32'h0);
        chk("misc", 32'h0, rd);
        wb_io(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Mixed directions across the port; pin 7 stays quiet in its reset role.
        wb_io(1'b1, 8'h04, 32'h8d);
        wb_io(1'b1, 8'h00, 32'h85);
        wt(2);
        chk("oe", 32'h0d, pa_oe_o);
        chk("out", 32'h05, pa_out_o);
        wb_io(1'b0, 8'h04, 32'h0);
        chk("dir", 32'h8d, rd);
        // Enable without select, then select without enable, keep port logic.
        @(posedge clk_i) pulse_ch_i <= 3'h2;
        wb_io(1'b1, 8'h08, 32'h07);
        wt(2);
        chk("out", 32'h05, pa_out_o);
        wb_io(1'b1, 8'h08, 32'h00);
        wb_io(1'b1, 8'h0c, 32'h07);
        wt(2);
        chk("out", 32'h05, pa_out_o);
        wb_io(1'b1, 8'h08, 32'h03);
        wt(2);
        chk("out", 32'h06, pa_out_o);
        @(posedge clk_i) pulse_ch_i <= 3'h5;
        wt(2);
        chk("out", 32'h05, pa_out_o);
        // Pin 2 channel low against a high data bit, so routing shows.
        @(posedge clk_i) pulse_ch_i <= 3'h1;
        wb_io(1'b1, 8'h08, 32'h07);
        wt(2);
        chk("out", 32'h01, pa_out_o);
        // Clock source choice follows mode and source bits.
        @(posedge clk_i) clock_input_pin_i <= 1'b1;
        wb_io(1'b1, 8'h10, 32'h01);
        wt(2);
        chk("clk_en", 32'h1, ext_clk_en_o);
        chk("clk", 32'h1, ext_clk_o);
        wb_io(1'b1, 8'h10, 32'h03);
        wt(2);
        chk("clk", 32'h0, ext_clk_o);
        @(posedge clk_i) crystal_pin_i <= 1'b1;
        wt(2);
        chk("clk", 32'h1, ext_clk_o);
        wb_io(1'b0, 8'h10, 32'h0);
        chk("osc", 32'h3, rd);
        // Pin 7 as port pin: a low level no longer resets.
        wb_io(1'b1, 8'h18, 32'h01);
        @(posedge clk_i) pa_in_i <= 8'h5a;
        wt(3);
        chk("rst", 32'h0, int_rst_o);
        chk("oe", 32'h8f, pa_oe_o);
        wb_io(1'b0, 8'h14, 32'h0);
        chk("pins", 32'h5a, rd);
        // A watchdog request still resets and restores the reset role.
        @(posedge clk_i) wdog_rst_i <= 1'b1;
        @(posedge clk_i) wdog_rst_i <= 1'b0;
        wb_io(1'b0, 8'h1c, 32'h0);
        chk("status", 32'h1, rd);
        @(posedge clk_i) pa_in_i <= 8'h80;
        rel();
        wb_io(1'b0, 8'h18, 32'h0);
        chk("misc", 32'h0, rd);
        wb_io(1'b0, 8'h04, 32'h0);
        chk("dir", 32'h0, rd);
        // A low reset pin holds reset while it stays low.
        wb_io(1'b1, 8'h04, 32'h01);
        @(posedge clk_i) pa_in_i <= 8'h00;
        wt(40);
        chk("rst", 32'h1, int_rst_o);
        @(posedge clk_i) pa_in_i <= 8'h80;
        rel();
        chk("rst", 32'h0, int_rst_o);
        wb_io(1'b0, 8'h04, 32'h0);
        chk("dir", 32'h0, rd);
        // Software reset.
        wb_io(1'b1, 8'h18, 32'h02);
        wt(1);
        chk("rst", 32'h1, int_rst_o);
        rel();
        // The source fell at the last edge of wb_io; the first quiet edge passed inside wt(1).
        chk("count", 32, n);
        wrap_up();
    end
endmodule
